// ==== design/flash_clock_and_option_regs.sv ====
`default_nettype none
module flash_clock_and_option_regs
   import flash_regs_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_N,
   input wire wb_req_type WB_REQ,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   input wire logic SRC_SECURE,
   input wire logic SRC_DEBUG,
   input wire logic [7:0] NV_OPTION_BYTE,
   input wire logic [7:0] NV_GUARD_BYTE,
   input wire logic [63:0] STORED_UNLOCK_KEY,
   input wire logic BLANK_CHECK_OK,
   output logic FLASH_TICK,
   output logic PE_ALLOW,
   output logic PE_BUSY,
   output logic SECURED,
   output logic VECTOR_REDIRECT_OFF,
   output logic MEMORY_BLOCK
);
   logic ack;
   logic [31:0] rdata;
   logic [7:0] flash_clock_setup;
   logic [7:0] flash_option_shadow;
   logic [7:0] flash_guard_shadow;
   logic key_compare_route;
   logic access_error_flag;
   logic shadows_loaded;
   logic [1:0] lock_state_code;
   logic [2:0] prescale_cnt;
   logic [5:0] ratio_cnt;
   logic tick;
   logic [6:0] pulses_left;
   logic [3:0] key_index;
   logic key_match;
   logic [7:0] key_byte [0:7];
   logic take;
   logic wr_fire;
   logic wr_byte;
   logic [7:0] wbyte;
   logic ratio_loaded_flag;
   logic div_in;
   logic key_hit;
   logic pe_attempt;
   logic unlock_now;
   logic [6:0] ratio_plus;
   logic [9:0] tick_period;
   logic [9:0] since_tick;

   // ----------------------------------------------------------------
   // bus slave
   // ----------------------------------------------------------------
   // request sampled on the take edge, write applied on the ack edge
   assign take = WB_REQ.cyc & WB_REQ.stb & ~ack;
   assign wr_fire = WB_REQ.cyc & WB_REQ.stb & WB_REQ.we & ack;
   assign wr_byte = wr_fire & WB_REQ.sel[0];
   assign wbyte = WB_REQ.dat[7:0];
   assign key_hit = WB_REQ.adr[5] == KEY_BASE_ADDR[5];
   assign ratio_loaded_flag = flash_clock_setup[LOADED_BIT];

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ack <= 1'b0;
      end else begin
         ack <= take;
      end
   end

   always_comb begin
      rdata = 32'h0000_0000;
      if (WB_REQ.adr == CLOCK_SETUP_ADDR) begin
         rdata[7:0] = flash_clock_setup;
      end else if (WB_REQ.adr == OPTION_ADDR) begin
         rdata[7:0] = {flash_option_shadow[7:2], lock_state_code};
      end else if (WB_REQ.adr == GUARD_ADDR) begin
         rdata[7:0] = flash_guard_shadow;
      end else if (WB_REQ.adr == CONFIG_ADDR) begin
         rdata[KEY_ROUTE_BIT] = key_compare_route;
      end else if (WB_REQ.adr == STATUS_ADDR) begin
         rdata[ACCESS_ERROR_BIT] = access_error_flag;
      end else if (WB_REQ.adr == COMMAND_ADDR) begin
         rdata[7:0] = {PE_BUSY, pulses_left};
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         WB_DAT_O <= 32'h0000_0000;
      end else if (take) begin
         WB_DAT_O <= rdata;
      end
   end
   assign WB_ACK_O = ack;

   // ----------------------------------------------------------------
   // clock setup register
   // ----------------------------------------------------------------
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         flash_clock_setup <= CLOCK_SETUP_RESET;
      end else if (wr_byte && WB_REQ.adr == CLOCK_SETUP_ADDR && !ratio_loaded_flag) begin
         // write-once: data bits and flag all latch on the first write
         flash_clock_setup <= {1'b1, wbyte[6:0]};
      end
   end

   // ----------------------------------------------------------------
   // flash timing clock
   // ----------------------------------------------------------------
   assign div_in = flash_clock_setup[PRESCALE_BIT] ? (prescale_cnt == PRESCALE_LAST)
                                                  : 1'b1;

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         prescale_cnt <= 3'h0;
      end else begin
         prescale_cnt <= prescale_cnt + 3'h1;
      end
   end

   // held idle until the ratio is loaded, so no tick runs at a bogus rate
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         ratio_cnt <= 6'h00;
         tick <= 1'b0;
      end else begin
         tick <= 1'b0;
         if (ratio_loaded_flag && div_in) begin
            if (ratio_cnt == 6'h00) begin
               ratio_cnt <= flash_clock_setup[5:0];
               tick <= 1'b1;
            end else begin
               ratio_cnt <= ratio_cnt - 6'h01;
            end
         end
      end
   end
   assign FLASH_TICK = tick;

   // ----------------------------------------------------------------
   // flash tick period monitor
   // ----------------------------------------------------------------
   // bus clocks since the last tick; holds at zero until the first tick, saturates at 3FF
   assign ratio_plus = {1'b0, flash_clock_setup[5:0]} + 7'h01;
   assign tick_period = flash_clock_setup[PRESCALE_BIT] ? {ratio_plus, 3'h0}
                                                        : {3'h0, ratio_plus};

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         since_tick <= 10'h000;
      end else if (tick) begin
         since_tick <= 10'h001;
      end else if (since_tick != 10'h000 && since_tick != 10'h3FF) begin
         since_tick <= since_tick + 10'h001;
      end
   end

   // ----------------------------------------------------------------
   // program and erase timer
   // ----------------------------------------------------------------
   // a command write, or a key-location write while not routed to compare
   assign pe_attempt = wr_byte && (WB_REQ.adr == COMMAND_ADDR
                                   || (key_hit && !key_compare_route));
   assign PE_ALLOW = ratio_loaded_flag;

   // length is counted in whole flash clock pulses; a zero count is ignored
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         pulses_left <= 7'h00;
      end else if (pe_attempt && ratio_loaded_flag && pulses_left == 7'h00) begin
         pulses_left <= wbyte[6:0];
      end else if (tick && pulses_left != 7'h00) begin
         pulses_left <= pulses_left - 7'h01;
      end
   end
   assign PE_BUSY = pulses_left != 7'h00;

   // ----------------------------------------------------------------
   // status and configuration
   // ----------------------------------------------------------------
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         access_error_flag <= 1'b0;
      end else if (pe_attempt && !ratio_loaded_flag) begin
         access_error_flag <= 1'b1;
      end else if (wr_byte && WB_REQ.adr == STATUS_ADDR && wbyte[ACCESS_ERROR_BIT]) begin
         access_error_flag <= 1'b0;
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         key_compare_route <= 1'b0;
      end else if (wr_byte && WB_REQ.adr == CONFIG_ADDR) begin
         key_compare_route <= wbyte[KEY_ROUTE_BIT];
      end
   end

   // ----------------------------------------------------------------
   // backdoor key comparison
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : key_slice
         assign key_byte[g] = STORED_UNLOCK_KEY[8*g +: 8];
      end
   endgenerate

   // any out-of-order or wrong byte spoils the attempt until route reopens
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         key_index <= 4'h0;
         key_match <= 1'b0;
      end else if (wr_byte && WB_REQ.adr == CONFIG_ADDR && wbyte[KEY_ROUTE_BIT]
                   && !key_compare_route) begin
         key_index <= 4'h0;
         key_match <= 1'b1;
      end else if (wr_byte && key_hit && key_compare_route) begin
         if (!SRC_SECURE || SRC_DEBUG) begin
            key_match <= 1'b0;
         end else if (key_index < KEY_BYTES && {1'b0, WB_REQ.adr[4:2]} == key_index
                      && wbyte == key_byte[key_index[2:0]]) begin
            key_index <= key_index + 4'h1;
         end else begin
            key_match <= 1'b0;
         end
      end
   end

   assign unlock_now = wr_byte && WB_REQ.adr == CONFIG_ADDR && !wbyte[KEY_ROUTE_BIT]
                       && key_compare_route && key_match && key_index == KEY_BYTES
                       && flash_option_shadow[UNLOCK_ALLOW_BIT];

   // ----------------------------------------------------------------
   // nonvolatile shadows and security state
   // ----------------------------------------------------------------
   // reset only parks constants; the bytes are caught at the first edge after release
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         shadows_loaded <= 1'b0;
         flash_option_shadow <= OPTION_RESET;
         flash_guard_shadow <= GUARD_RESET;
      end else if (!shadows_loaded) begin
         shadows_loaded <= 1'b1;
         flash_option_shadow <= NV_OPTION_BYTE;
         flash_guard_shadow <= NV_GUARD_BYTE;
      end
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         lock_state_code <= OPTION_RESET[1:0];
      end else if (!shadows_loaded) begin
         lock_state_code <= NV_OPTION_BYTE[1:0];
      end else if (unlock_now || BLANK_CHECK_OK) begin
         lock_state_code <= UNSECURED_CODE;
      end
   end

   assign SECURED = lock_state_code != UNSECURED_CODE;
   assign VECTOR_REDIRECT_OFF = flash_option_shadow[REDIRECT_OFF_BIT];
   assign MEMORY_BLOCK = SECURED & (~SRC_SECURE | SRC_DEBUG);

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   write_once_a: assert property (@(posedge CLK) disable iff (!RST_N)
      $past(ratio_loaded_flag) |-> $stable(flash_clock_setup))
      else $error("clock setup changed after first write");

   flag_set_a: assert property (@(posedge CLK) disable iff (!RST_N)
      wr_byte && WB_REQ.adr == CLOCK_SETUP_ADDR |=> ratio_loaded_flag)
      else $error("loaded flag not set by write");

   pe_refused_a: assert property (@(posedge CLK) disable iff (!RST_N)
      !ratio_loaded_flag |-> !PE_BUSY && !tick)
      else $error("operation ran before clock setup");

   access_error_a: assert property (@(posedge CLK) disable iff (!RST_N)
      pe_attempt && !ratio_loaded_flag |=> access_error_flag)
      else $error("access error not raised");

   tick_spacing_a: assert property (@(posedge CLK) disable iff (!RST_N)
      tick && !flash_clock_setup[PRESCALE_BIT] && flash_clock_setup[5:0] == 6'h03
      |=> !tick [*3] ##1 tick)
      else $error("flash tick period wrong");

   prescale_gap_a: assert property (@(posedge CLK) disable iff (!RST_N)
      tick && flash_clock_setup[PRESCALE_BIT] |=> !tick [*7])
      else $error("prescaled tick too early");

   unlock_force_a: assert property (@(posedge CLK) disable iff (!RST_N)
      shadows_loaded && (unlock_now || BLANK_CHECK_OK) |=> !SECURED)
      else $error("lock code not forced open");

   key_gate_a: assert property (@(posedge CLK) disable iff (!RST_N)
      shadows_loaded && !BLANK_CHECK_OK && !flash_option_shadow[UNLOCK_ALLOW_BIT]
      |=> $stable(lock_state_code))
      else $error("lock code opened with key disabled");

   shadow_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
      $past(shadows_loaded) |-> $stable(flash_option_shadow))
      else $error("option shadow changed without reset");

   block_a: assert property (@(posedge CLK) disable iff (!RST_N)
      SECURED && SRC_DEBUG |-> MEMORY_BLOCK)
      else $error("debug access not blocked while secured");

   ack_pulse_a: assert property (@(posedge CLK) disable iff (!RST_N)
      WB_ACK_O |=> !WB_ACK_O)
      else $error("ack held longer than one cycle");

   ack_answer_a: assert property (@(posedge CLK) disable iff (!RST_N)
      WB_REQ.cyc && WB_REQ.stb && !WB_ACK_O |=> WB_ACK_O)
      else $error("request not answered next cycle");

   tick_period_a: assert property (@(posedge CLK) disable iff (!RST_N)
      tick && since_tick != 10'h000 |-> since_tick == tick_period)
      else $error("flash tick period differs from divisor");

   busy_end_a: assert property (@(posedge CLK) disable iff (!RST_N)
      $fell(PE_BUSY) |-> $past(tick))
      else $error("operation ended between flash ticks");

   debug_key_a: assert property (@(posedge CLK) disable iff (!RST_N)
      wr_byte && key_hit && key_compare_route && (SRC_DEBUG || !SRC_SECURE)
      |=> !key_match)
      else $error("insecure key write kept the attempt alive");

   key_route_a: assert property (@(posedge CLK) disable iff (!RST_N)
      wr_byte && key_hit && key_compare_route |=> !$rose(PE_BUSY))
      else $error("key comparison write started an operation");

   guard_hold_a: assert property (@(posedge CLK) disable iff (!RST_N)
      $past(shadows_loaded) |-> $stable(flash_guard_shadow))
      else $error("guard shadow changed without reset");

   setup_written_c: cover property (@(posedge CLK) disable iff (!RST_N)
      $rose(ratio_loaded_flag));
   op_done_c: cover property (@(posedge CLK) disable iff (!RST_N)
      $fell(PE_BUSY));
   key_unlock_c: cover property (@(posedge CLK) disable iff (!RST_N)
      unlock_now);
   early_pe_c: cover property (@(posedge CLK) disable iff (!RST_N)
      $rose(access_error_flag));
   prescaled_tick_c: cover property (@(posedge CLK) disable iff (!RST_N)
      tick && flash_clock_setup[PRESCALE_BIT]);
endmodule
`default_nettype wire

// ==== design/flash_regs_pkg.sv ====
// Function
// - six byte-wide control registers; option and guard bytes copied in at every reset
// - ratio_loaded_flag bit 7 read-only, cleared by reset, set by first write
// - bits 6:0 always readable, only first write after reset updates them
// - program and erase refused while ratio_loaded_flag is 0, allowed once 1
// - prescale_by_eight 1 feeds divider with bus clock over eight, else bus clock
// - flash clock equals divider input over ratio field plus one
// - each timing pulse is one flash clock; operations last whole pulses
// - option shadow loaded at reset only; changes after reprogram and new reset
// - unlock allow 0 blocks backdoor; 1 lets ascending eight-byte key unsecure
// - key comparison writes refused from debug or unsecured sources
// - option bit 6 at 1 disables vector redirection, 0 enables it
// - lock code 1:0 means unsecured; 0:0, 0:1, 1:1 mean secured
// - while secured, RAM and flash access from unsecured sources is blocked
// - lock code forced to 1:0 after key match or successful blank check
// - key_compare_route 1 makes key location writes comparisons, not commands
// - access_error_flag set on program or erase before clock setup written
`default_nettype none
package flash_regs_pkg;
   // ----------------------------------------------------------------
   // register byte addresses
   // ----------------------------------------------------------------
   localparam logic [5:0] CLOCK_SETUP_ADDR = 6'h00;
   localparam logic [5:0] OPTION_ADDR = 6'h04;
   localparam logic [5:0] GUARD_ADDR = 6'h08;
   localparam logic [5:0] CONFIG_ADDR = 6'h0C;
   localparam logic [5:0] STATUS_ADDR = 6'h10;
   localparam logic [5:0] COMMAND_ADDR = 6'h14;
   localparam logic [5:0] KEY_BASE_ADDR = 6'h20;
   // ----------------------------------------------------------------
   // field positions and values
   // ----------------------------------------------------------------
   localparam int LOADED_BIT = 7;
   localparam int PRESCALE_BIT = 6;
   localparam int UNLOCK_ALLOW_BIT = 7;
   localparam int REDIRECT_OFF_BIT = 6;
   localparam int KEY_ROUTE_BIT = 5;
   localparam int ACCESS_ERROR_BIT = 4;
   localparam int BUSY_BIT = 7;
   localparam logic [1:0] UNSECURED_CODE = 2'h2;
   localparam logic [7:0] CLOCK_SETUP_RESET = 8'h00;
   localparam logic [7:0] OPTION_RESET = 8'hFF;
   localparam logic [7:0] GUARD_RESET = 8'hFF;
   localparam logic [2:0] PRESCALE_LAST = 3'h7;
   localparam logic [3:0] KEY_BYTES = 4'h8;
   // ----------------------------------------------------------------
   // bus request carrier
   // ----------------------------------------------------------------
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [5:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } wb_req_type;
endpackage
`default_nettype wire

// ==== dv/flash_clock_and_option_regs_tb.sv ====
`default_nettype none
module flash_clock_and_option_regs_tb import flash_regs_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   // ----------------------------------------------------------------
   // stimulus and observation
   // ----------------------------------------------------------------
   localparam logic [63:0] KEY = 64'h0123456789ABCDEF;
   localparam logic [7:0] GUARD = 8'h5A;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   wb_req_type req = '0;
   logic [31:0] dat_o;
   logic ack, tick, pe_allow, pe_busy, secured, redirect_off, mem_block;
   logic src_secure = 1'b1;
   logic src_debug = 1'b0;
   logic blank_ok = 1'b0;
   logic [7:0] nv_option = 8'h83;
   int n_fail = 0;
   int tests_run = 0;
   int cycles = 0;
   int busy_cycles = 0;
   int g;

   flash_clock_and_option_regs dut (.CLK(clk), .RST_N(rst_n), .WB_REQ(req), .WB_DAT_O(dat_o),
      .WB_ACK_O(ack), .SRC_SECURE(src_secure), .SRC_DEBUG(src_debug),
      .NV_OPTION_BYTE(nv_option), .NV_GUARD_BYTE(GUARD), .STORED_UNLOCK_KEY(KEY),
      .BLANK_CHECK_OK(blank_ok), .FLASH_TICK(tick), .PE_ALLOW(pe_allow), .PE_BUSY(pe_busy),
      .SECURED(secured), .VECTOR_REDIRECT_OFF(redirect_off), .MEMORY_BLOCK(mem_block));

   initial begin
      forever #10 clk = ~clk;
   end

   // whole run needs under two thousand cycles; the ceiling leaves ample room
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (pe_busy === 1'b1) begin
         busy_cycles <= busy_cycles + 1;
      end
      if (cycles == 30000) begin
         n_fail++;
         test_done();
      end
   end

   // ----------------------------------------------------------------
   // tasks; each is entered and left just after a rising edge
   // ----------------------------------------------------------------
   task automatic test_done();
      if (n_fail == 0 && tests_run > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic bus(input logic we, input logic [5:0] adr, input logic [7:0] wd,
                      output logic [31:0] rd);
      int n;
      n = 0;
      req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'h1, dat: {24'h0, wd}};
      @(posedge clk);
      while (ack !== 1'b1 && n < 50) begin
         @(posedge clk);
         n++;
      end
      rd = dat_o;
      check("ack", ack, 1'b1);
      req <= '0;
      @(posedge clk);
   endtask

   task automatic wr(input logic [5:0] adr, input logic [7:0] wd);
      logic [31:0] rd;
      bus(1'b1, adr, wd, rd);
   endtask

   task automatic rd_chk(input string what, input logic [5:0] adr, input logic [7:0] exp);
      logic [31:0] rd;
      bus(1'b0, adr, 8'h00, rd);
      check(what, rd, {24'h0, exp});
   endtask

   task automatic do_reset(input int n);
      rst_n <= 1'b0;
      repeat (n) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
   endtask

   task automatic tick_gap(output int gap);
      int n;
      n = 0;
      while (tick !== 1'b1 && n < 400) begin
         @(posedge clk);
         n++;
      end
      gap = 0;
      do begin
         @(posedge clk);
         gap++;
      end while (tick !== 1'b1 && gap < 400);
   endtask

   // debug source on byte bad_byte spoils the attempt; 8 means none
   task automatic key_try(input int bad_byte);
      wr(CONFIG_ADDR, 8'h20);
      for (int k = 0; k < 8; k++) begin
         src_debug <= (k == bad_byte);
         wr(KEY_BASE_ADDR + 6'(4 * k), KEY[8*k +: 8]);
      end
      src_debug <= 1'b0;
      wr(CONFIG_ADDR, 8'h00);
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      rd_chk("option", OPTION_ADDR, 8'h83);
      rd_chk("guard", GUARD_ADDR, GUARD);
      check("secured", secured, 1'b1);
      check("redirect_off", redirect_off, 1'b0);
      src_secure <= 1'b0;
      @(posedge clk);
      check("mem_block", mem_block, 1'b1);
      src_secure <= 1'b1;
      src_debug <= 1'b1;
      @(posedge clk);
      check("mem_block_dbg", mem_block, 1'b1);
      src_debug <= 1'b0;
      @(posedge clk);
      check("mem_block_sec", mem_block, 1'b0);
      nv_option <= 8'h43;
      wr(OPTION_ADDR, 8'h00);
      rd_chk("option_ro", OPTION_ADDR, 8'h83);
      rd_chk("setup_rst", CLOCK_SETUP_ADDR, 8'h00);
      check("pe_allow0", pe_allow, 1'b0);
      wr(COMMAND_ADDR, 8'h03);
      check("busy_refused", busy_cycles, 0);
      rd_chk("acc_err", STATUS_ADDR, 8'h10);
      wr(STATUS_ADDR, 8'h10);
      rd_chk("acc_err_clr", STATUS_ADDR, 8'h00);
      wr(6'h18, 8'hFF);
      rd_chk("unmapped", 6'h18, 8'h00);
      // 50 MHz over 8 over 32: flash clock near 195 kHz before any operation
      wr(CLOCK_SETUP_ADDR, 8'h5F);
      rd_chk("setup_first", CLOCK_SETUP_ADDR, 8'hDF);
      check("pe_allow1", pe_allow, 1'b1);
      wr(CLOCK_SETUP_ADDR, 8'h7F);
      rd_chk("setup_second", CLOCK_SETUP_ADDR, 8'hDF);
      tick_gap(g);
      check("tick_gap", g, 256);
      busy_cycles = 0;
      wr(COMMAND_ADDR, 8'h03);
      repeat (800) @(posedge clk);
      check("busy_len", (busy_cycles > 512) && (busy_cycles <= 768), 1'b1);
      rd_chk("no_err", STATUS_ADDR, 8'h00);
      busy_cycles = 0;
      key_try(2);
      check("key_debug", secured, 1'b1);
      key_try(8);
      check("key_cmds", busy_cycles, 0);
      check("key_unlock", secured, 1'b0);
      rd_chk("option_code", OPTION_ADDR, 8'h82);
      // fresh reset picks up the reprogrammed byte: key disabled, redirect off
      do_reset(4);
      rd_chk("option_new", OPTION_ADDR, 8'h43);
      check("redirect_off1", redirect_off, 1'b1);
      rd_chk("setup_cleared", CLOCK_SETUP_ADDR, 8'h00);
      key_try(8);
      check("key_disabled", secured, 1'b1);
      blank_ok <= 1'b1;
      @(posedge clk);
      blank_ok <= 1'b0;
      repeat (2) @(posedge clk);
      check("blank_unlock", secured, 1'b0);
      // no operation follows, so the undivided fast rate is harmless here
      wr(CLOCK_SETUP_ADDR, 8'h03);
      rd_chk("setup_fast", CLOCK_SETUP_ADDR, 8'h83);
      tick_gap(g);
      tick_gap(g);
      check("tick_gap_fast", g, 4);
      for (int c = 0; c < 4; c++) begin
         nv_option <= {6'h00, 2'(c)};
         do_reset(2);
         check("lock_code", secured, 1'(c != 2));
      end
      test_done();
   end
endmodule
`default_nettype wire
